// file: logic/ldes_regs.sv
`timescale 1ns/10ps
module ldes_regs #(
	parameter int unsigned INTERVAL_CYC = ldes_pkg::DET_INTERVAL_CYC,
	parameter int unsigned ATTEMPTS     = ldes_pkg::DET_ATTEMPTS
) (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       override_detect_i,
	input  wire logic       override_mode_i,
	input  wire logic [1:0] receiver_detect_pin_i,
	input  wire logic       mode_pin_i,
	input  wire logic [1:0] rx_found_i,
	output logic      [1:0] det_try_o,
	output logic      [1:0] term_50_o,
	output logic      [7:0] port_a_equalizer_level_o,
	output logic      [7:0] port_b_equalizer_level_o,
	output logic            short_prot_en_o,
	output logic            mode_gen12_o,
	output logic      [2:0] output_swing_level_o
);
	localparam int unsigned NL = ldes_pkg::NUM_LANES;
	localparam int unsigned NR = ldes_pkg::NUM_REGS;

	typedef struct packed {
		logic [NR-1:0][7:0] regs;
		logic [7:0]         rdata;
		logic [1:0]         det_pin_s1;
		logic [1:0]         det_pin_s2;
		logic               mode_s1;
		logic               mode_s2;
		logic [NL-1:0]      found_s1;
		logic [NL-1:0]      found_s2;
		logic [NL-1:0][1:0] code_prev;
		logic [NL-1:0]      rewrite;
	} ldes_regs_st_t;

	ldes_regs_st_t      st_r;
	ldes_regs_st_t      st_nxt;
	logic [NL-1:0][1:0] eff_code;
	logic [NL-1:0]      restart;
	logic [NL-1:0]      tick;

	// effective detect code per lane and restart condition
	genvar l;
	generate
		for (l = 0; l < NL; l++) begin : g_lane
			assign eff_code[l] = override_detect_i ?
				st_r.regs[ldes_pkg::LANE_DET_IDX[l]]
					[ldes_pkg::DET_FLD_HI:ldes_pkg::DET_FLD_LO] :
				st_r.det_pin_s2; // RL6 RL13
			assign restart[l] = st_r.rewrite[l] ||
				(eff_code[l] != st_r.code_prev[l]); // RL15

			ldes_tick #(
				.PERIOD (INTERVAL_CYC)
			) u_tick (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.restart_i (restart[l]),
				.tick_o    (tick[l])
			);

			ldes_det #(
				.ATTEMPTS (ATTEMPTS)
			) u_det (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.code_i    (eff_code[l]),
				.restart_i (restart[l]),
				.tick_i    (tick[l]),
				.found_i   (st_r.found_s2[l]),
				.term_50_o (term_50_o[l]),
				.try_o     (det_try_o[l])
			);
		end
	endgenerate

	always_comb begin
		st_nxt            = st_r;
		st_nxt.det_pin_s1 = receiver_detect_pin_i;
		st_nxt.det_pin_s2 = st_r.det_pin_s1;
		st_nxt.mode_s1    = mode_pin_i;
		st_nxt.mode_s2    = st_r.mode_s1;
		st_nxt.found_s1   = rx_found_i;
		st_nxt.found_s2   = st_r.found_s1;
		st_nxt.code_prev  = eff_code;
		st_nxt.rewrite    = '0;
		st_nxt.rdata      = 8'h00;
		// whole-byte writes, reserved bits and registers just store
		for (int i = 0; i < NR; i++) begin
			if (reg_wr_i && reg_addr_i == ldes_pkg::REG_ADDR[i]) begin
				st_nxt.regs[i] = reg_wdata_i; // RL7 RL16
			end
			if (reg_addr_i == ldes_pkg::REG_ADDR[i]) begin
				st_nxt.rdata = st_r.regs[i];
			end
		end
		for (int k = 0; k < NL; k++) begin
			if (reg_wr_i && reg_addr_i ==
				ldes_pkg::REG_ADDR[ldes_pkg::LANE_DET_IDX[k]]) begin
				st_nxt.rewrite[k] = 1'b1; // RL15
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= '{regs: ldes_pkg::REG_RST, default: '0}; // RL7 RL12 RL16
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o              = st_r.rdata;
	assign port_a_equalizer_level_o = st_r.regs[ldes_pkg::IDX_PA_EQL]; // RL7
	assign port_b_equalizer_level_o = st_r.regs[ldes_pkg::IDX_PB_EQL]; // RL7
	assign short_prot_en_o =
		st_r.regs[ldes_pkg::IDX_SWING][ldes_pkg::SCP_BIT]; // RL8
	assign mode_gen12_o = override_mode_i ?
		st_r.regs[ldes_pkg::IDX_SWING][ldes_pkg::MODE_BIT] :
		st_r.mode_s2; // RL9 RL10 RL14
	assign output_swing_level_o = st_r.regs[ldes_pkg::IDX_SWING]
		[ldes_pkg::SWING_HI:ldes_pkg::SWING_LO]; // RL12
endmodule : ldes_regs

// file: logic/ldes_pkg.sv
// How it works
// [RL1] detect field sits in bits 3:2; code 00 keeps termination high impedance
// [RL2] code 01 tries every 12 ms, gives up after 50 tries
// [RL3] code 10 tries every 12 ms until a receiver is found
// [RL4] auto modes stay high impedance until found, then 50 ohm
// [RL5] code 11 gives 50 ohm at once, no tries
// [RL6] register detect field governs only under detect override, else pin
// [RL7] each input lane has an 8-bit equalizer level, reset 0x2f
// [RL8] swing register bit 7 enables short-circuit protection
// [RL9] swing register bit 6: 1 gen1/2 or 10ge, 0 gen3 or kr
// [RL10] register mode bit applies only under mode override, else pin
// [RL11] host keeps bits 5:3 of swing register at 101
// [RL12] swing bits 2:0 pick output amplitude; register resets to 0xad
// [RL13] override bit 3 set blocks detect pin, per-lane fields apply
// [RL14] override bit 2 set blocks mode pin, register bit applies
// [RL15] interval and try count from a clock counter, restarted on rewrite
// [RL16] reserved registers reset to defaults and just store writes
package ldes_pkg;
	localparam int unsigned CLK_HZ           = 40_000_000;
	localparam int unsigned DET_INTERVAL_MS  = 12;
	localparam int unsigned DET_LIMIT_MS     = 600;
	localparam int unsigned DET_INTERVAL_CYC =
		CLK_HZ / 1000 * DET_INTERVAL_MS;
	localparam int unsigned DET_ATTEMPTS     = DET_LIMIT_MS / DET_INTERVAL_MS;
	localparam int unsigned NUM_LANES        = 2;
	localparam int unsigned NUM_REGS         = 8;

	localparam logic [7:0] ADDR_PA_DET = 8'h0e;
	localparam logic [7:0] ADDR_PA_EQL = 8'h0f;
	localparam logic [7:0] ADDR_RSV_A  = 8'h10;
	localparam logic [7:0] ADDR_RSV_B  = 8'h11;
	localparam logic [7:0] ADDR_RSV_C  = 8'h12;
	localparam logic [7:0] ADDR_PB_DET = 8'h15;
	localparam logic [7:0] ADDR_PB_EQL = 8'h16;
	localparam logic [7:0] ADDR_SWING  = 8'h17;

	localparam logic [7:0] RST_DET   = 8'h00;
	localparam logic [7:0] RST_EQL   = 8'h2f;
	localparam logic [7:0] RST_RSV_A = 8'had;
	localparam logic [7:0] RST_RSV_B = 8'h02;
	localparam logic [7:0] RST_RSV_C = 8'h00;
	localparam logic [7:0] RST_SWING = 8'had;

	// entry i of the register file
	localparam logic [7:0][7:0] REG_ADDR = {ADDR_SWING, ADDR_PB_EQL,
		ADDR_PB_DET, ADDR_RSV_C, ADDR_RSV_B, ADDR_RSV_A, ADDR_PA_EQL,
		ADDR_PA_DET};
	localparam logic [7:0][7:0] REG_RST = {RST_SWING, RST_EQL, RST_DET,
		RST_RSV_C, RST_RSV_B, RST_RSV_A, RST_EQL, RST_DET};

	localparam logic [2:0] IDX_PA_DET = 3'h0;
	localparam logic [2:0] IDX_PA_EQL = 3'h1;
	localparam logic [2:0] IDX_PB_DET = 3'h5;
	localparam logic [2:0] IDX_PB_EQL = 3'h6;
	localparam logic [2:0] IDX_SWING  = 3'h7;
	localparam logic [1:0][2:0] LANE_DET_IDX = {IDX_PB_DET, IDX_PA_DET};

	localparam int unsigned DET_FLD_HI = 3;
	localparam int unsigned DET_FLD_LO = 2;
	localparam int unsigned SCP_BIT    = 7;
	localparam int unsigned MODE_BIT   = 6;
	localparam int unsigned SWING_HI   = 2;
	localparam int unsigned SWING_LO   = 0;

	localparam logic [1:0] DET_OFF     = 2'h0;
	localparam logic [1:0] DET_LIMITED = 2'h1;
	localparam logic [1:0] DET_ENDLESS = 2'h2;
	localparam logic [1:0] DET_FIXED   = 2'h3;

	typedef enum logic [4:0] {
		LDES_DET_HIZ    = 5'h01,
		LDES_DET_SEARCH = 5'h02,
		LDES_DET_FOUND  = 5'h04,
		LDES_DET_GAVEUP = 5'h08,
		LDES_DET_FIXED  = 5'h10
	} ldes_det_state_t;
endpackage : ldes_pkg

// file: logic/ldes_tick.sv
`timescale 1ns/10ps
module ldes_tick #(
	parameter int unsigned PERIOD = ldes_pkg::DET_INTERVAL_CYC
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic restart_i,
	output logic      tick_o
);
	localparam int unsigned CW = $clog2(PERIOD + 1);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} ldes_tick_st_t;

	ldes_tick_st_t st_r;
	ldes_tick_st_t st_nxt;

	// interval counter, restarted on detect rewrite
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (restart_i) begin
			st_nxt.cnt = '0; // RL15
		end else if (st_r.cnt == LAST) begin
			st_nxt.cnt  = '0;
			st_nxt.tick = 1'b1; // RL15
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = st_r.tick;
endmodule : ldes_tick

// file: logic/ldes_det.sv
`timescale 1ns/10ps
module ldes_det #(
	parameter int unsigned ATTEMPTS = ldes_pkg::DET_ATTEMPTS
) (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [1:0] code_i,
	input  wire logic       restart_i,
	input  wire logic       tick_i,
	input  wire logic       found_i,
	output logic            term_50_o,
	output logic            try_o
);
	localparam int unsigned AW = $clog2(ATTEMPTS + 1);
	localparam logic [AW-1:0] LIMIT = AW'(ATTEMPTS);

	typedef struct packed {
		ldes_pkg::ldes_det_state_t state;
		logic [AW-1:0]             cnt;
		logic                      try_p;
		logic                      term;
	} ldes_det_st_t;

	ldes_det_st_t st_r;
	ldes_det_st_t st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.try_p = 1'b0;
		if (restart_i) begin
			st_nxt.cnt = '0; // RL15
			case (code_i)
				ldes_pkg::DET_OFF:     st_nxt.state = ldes_pkg::LDES_DET_HIZ; // RL1
				ldes_pkg::DET_LIMITED,
				ldes_pkg::DET_ENDLESS: st_nxt.state = ldes_pkg::LDES_DET_SEARCH;
				default:               st_nxt.state = ldes_pkg::LDES_DET_FIXED; // RL5
			endcase
		end else begin
			case (st_r.state)
				ldes_pkg::LDES_DET_SEARCH: begin
					if (found_i) begin
						st_nxt.state = ldes_pkg::LDES_DET_FOUND; // RL4
					end else if (tick_i) begin
						if (code_i == ldes_pkg::DET_LIMITED && st_r.cnt == LIMIT) begin
							st_nxt.state = ldes_pkg::LDES_DET_GAVEUP; // RL2
						end else begin
							st_nxt.try_p = 1'b1; // RL2 RL3
							if (st_r.cnt != LIMIT) begin
								st_nxt.cnt = st_r.cnt + 1'b1;
							end
						end
					end
				end
				ldes_pkg::LDES_DET_HIZ,
				ldes_pkg::LDES_DET_FOUND,
				ldes_pkg::LDES_DET_GAVEUP,
				ldes_pkg::LDES_DET_FIXED: st_nxt.state = st_r.state;
				default: st_nxt.state = ldes_pkg::LDES_DET_HIZ;
			endcase
		end
		st_nxt.term = (st_nxt.state == ldes_pkg::LDES_DET_FOUND) ||
			(st_nxt.state == ldes_pkg::LDES_DET_FIXED); // RL4 RL5
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r <= '{state: ldes_pkg::LDES_DET_HIZ, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign term_50_o = st_r.term;
	assign try_o     = st_r.try_p;
endmodule : ldes_det

// file: sim/ldes_regs_chk.sv
`timescale 1ns/10ps
module ldes_regs_chk #(
	parameter int unsigned INTERVAL_CYC = 20,
	parameter int unsigned ATTEMPTS     = 3
) (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       override_detect_i,
	input wire logic       override_mode_i,
	input wire logic [1:0] receiver_detect_pin_i,
	input wire logic       mode_pin_i,
	input wire logic [1:0] rx_found_i,
	input wire logic [1:0] det_try_o,
	input wire logic [1:0] term_50_o,
	input wire logic [7:0] port_a_equalizer_level_o,
	input wire logic [7:0] port_b_equalizer_level_o,
	input wire logic       short_prot_en_o,
	input wire logic       mode_gen12_o,
	input wire logic [2:0] output_swing_level_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic w17;
	assign w17 = reg_wr_i && reg_addr_i == 8'h17;
	a_swing_level: assert property (w17 |=>
		output_swing_level_o == $past(reg_wdata_i[2:0])) else $error("swing");
	a_short_prot: assert property (w17 |=>
		short_prot_en_o == $past(reg_wdata_i[7])) else $error("short prot");
	a_eq_lane_a: assert property (reg_wr_i && reg_addr_i == 8'h0f |=>
		port_a_equalizer_level_o == $past(reg_wdata_i)) else $error("eq a");
	a_mode_reg: assert property (w17 ##1 override_mode_i |->
		mode_gen12_o == $past(reg_wdata_i[6])) else $error("mode reg");
	a_mode_pin: assert property ((!override_mode_i &&
		$stable(mode_pin_i))[*4] |-> mode_gen12_o == mode_pin_i)
		else $error("mode pin");
	a_term_fixed: assert property (reg_wr_i && reg_addr_i == 8'h15 &&
		reg_wdata_i[3:2] == 2'h3 ##1 override_detect_i[*5] |-> term_50_o[1])
		else $error("fixed term");
	a_try_gap: assert property (det_try_o[0] |=>
		(!det_try_o[0])[*8]) else $error("try gap");
	a_found_term: assert property (det_try_o[1] ##1
		rx_found_i[1][*4] |-> term_50_o[1]) else $error("found term");
	cover property (det_try_o[0]);
	cover property (term_50_o == 2'h3);
	cover property (w17 && override_mode_i);
endmodule : ldes_regs_chk

// file: sim/ldes_host.sv
`timescale 1ns/10ps
module ldes_host (
	input  wire logic       clk_i,
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = (a == 8'h17) ? {d[7:6], 3'h5, d[2:0]} : d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~reg_wdata_o;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk_i);
		reg_addr_o = a;
	endtask : rd
endmodule : ldes_host

// file: sim/ldes_regs_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin \
	checked++; \
	if ((e) !== (s)) begin \
		n_mismatch++; \
		$display("[FAIL] %s exp %h got %h", nm, e, s); \
	end \
end
module ldes_regs_bench;
	localparam int unsigned IVL = 20;
	localparam int unsigned ATT = 3;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        reg_wr_i, short_prot_en_o, mode_gen12_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, d;
	logic        override_detect_i = 1'b0;
	logic        override_mode_i = 1'b0;
	logic        mode_pin_i = 1'b0;
	logic [1:0]  receiver_detect_pin_i = 2'h0;
	logic [1:0]  rx_found_i = 2'h0;
	logic [1:0]  det_try_o, term_50_o;
	logic [7:0]  port_a_equalizer_level_o, port_b_equalizer_level_o;
	logic [2:0]  output_swing_level_o;
	logic [7:0]  exp_r [8];
	logic [19:0] q [$];
	logic        due = 1'b0;
	string       nm [5] = '{"rdata", "term", "swing", "eq", "tries"};
	int          n_mismatch = 0;
	int          checked = 0;
	int          tries = 0;
	always #12.5 clk_i = ~clk_i;
	ldes_host host (.clk_i(clk_i), .reg_addr_o(reg_addr_i),
		.reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
	ldes_regs #(.INTERVAL_CYC(IVL), .ATTEMPTS(ATT)) dut (.*);
	always @(posedge clk_i) if (det_try_o[0]) tries++;
	function automatic logic [15:0] obs(input logic [3:0] s);
		case (s)
			4'h0: obs = {8'h00, reg_rdata_o};
			4'h1: obs = {14'h0, term_50_o};
			4'h2: obs = {11'h0, short_prot_en_o, mode_gen12_o,
				output_swing_level_o};
			4'h3: obs = {port_a_equalizer_level_o, port_b_equalizer_level_o};
			default: obs = tries[15:0];
		endcase
	endfunction : obs
	always @(posedge due) begin : watch
		logic [19:0] e;
		e = q.pop_front();
		`CHK(nm[e[19:16]], e[15:0], obs(e[19:16]))
	end
	task automatic note(input logic [3:0] s, input logic [15:0] e);
		q.push_back({s, e});
		@(negedge clk_i);
		due = 1'b1;
		#1 due = 1'b0;
	endtask : note
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a);
		note(4'h0, {8'h00, e});
	endtask : rchk
	task automatic rst_chk;
		for (int i = 0; i < 8; i++) begin
			exp_r[i] = ldes_pkg::REG_RST[i];
			rchk(ldes_pkg::REG_ADDR[i], exp_r[i]);
		end
	endtask : rst_chk
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		void'($urandom(68));
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		rst_chk();
		rchk(8'h13, 8'h00);
		note(4'h2, 16'h0015);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom());
			exp_r[i] = (i == 7) ? {d[7:6], 3'h5, d[2:0]} : d;
			host.wr(ldes_pkg::REG_ADDR[i], d);
			rchk(ldes_pkg::REG_ADDR[i], exp_r[i]);
		end
		note(4'h3, {exp_r[1], exp_r[6]});
		override_mode_i = 1'b1;
		host.wr(8'h17, 8'h40);
		note(4'h2, 16'h0008);
		host.wr(8'h17, 8'hbf);
		note(4'h2, 16'h0017);
		override_mode_i = 1'b0;
		mode_pin_i = 1'b1;
		repeat (3) @(negedge clk_i);
		note(4'h2, 16'h001f);
		override_detect_i = 1'b1;
		host.wr(8'h15, 8'h0c);
		host.wr(8'h0e, 8'h00);
		repeat (4) @(negedge clk_i);
		note(4'h1, 16'h0002);
		override_detect_i = 1'b0;
		receiver_detect_pin_i = 2'h3;
		repeat (6) @(negedge clk_i);
		note(4'h1, 16'h0003);
		receiver_detect_pin_i = 2'h0;
		override_detect_i = 1'b1;
		host.wr(8'h15, 8'h08);
		host.wr(8'h0e, 8'h04);
		tries = 0;
		repeat ((ATT + 4) * IVL) @(negedge clk_i);
		note(4'h4, 16'(ATT));
		note(4'h1, 16'h0000);
		host.wr(8'h0e, 8'h08);
		tries = 0;
		repeat (6 * IVL + 10) @(negedge clk_i);
		note(4'h4, 16'h0006);
		@(posedge det_try_o[1]);
		@(negedge clk_i);
		rx_found_i = 2'h3;
		repeat (4) @(negedge clk_i);
		note(4'h1, 16'h0003);
		// reset in mid-run brings every register back to its default
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rst_chk();
		note(4'h1, 16'h0000);
		note(4'h2, 16'h001d);
		tally_and_finish();
	end
	initial begin
		repeat (2000) @(posedge clk_i);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : ldes_regs_bench
bind ldes_regs ldes_regs_chk #(.INTERVAL_CYC(INTERVAL_CYC),
	.ATTEMPTS(ATTEMPTS)) chk (.*);
